// file: sdp_fifo.sv
/*
 * byte fifo with valid and ready on both sides; depth a power of two.
 * assumes one clock and asynchronous active-low reset.
 */
`default_nettype none
module sdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   sdp_strm_if.src               dout
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      cnt_ff;
   logic [AW:0]      nxt_cnt;
   logic             avail_ff;

   wire push = in_valid && avail_ff;
   wire pop  = dout.valid && dout.ready;

   assign in_ready   = avail_ff;
   assign dout.valid = (cnt_ff != '0);
   assign dout.data  = mem_ff[rd_ptr_ff];
   assign nxt_cnt    = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge pclk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
         avail_ff  <= 1'b1;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + AW'(push);
         rd_ptr_ff <= rd_ptr_ff + AW'(pop);
         cnt_ff    <= nxt_cnt;
         avail_ff  <= (nxt_cnt != (AW+1)'(DEPTH));
      end
   end
endmodule : sdp_fifo
`default_nettype wire

// file: sdp_host_model.sv
/*
 * far-side model of the packer: serial byte source and frame sink.
 * assumes pclk shared with the packer; signals move just after rising edges.
 */
`default_nettype none
module sdp_host_model (
   input  wire logic       pclk,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output var  logic       tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // source and sink
   // ----------------------------------------
   logic       stall = 1'b0;
   logic [7:0] got[$];
   int         flen[$];
   int         cnt = 0;
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
   end
   // byte stays offered until taken or lim edges pass
   task automatic send(input logic [7:0] b, input int lim, output bit ok);
      ok = 1'b0;
      rx_valid <= 1'b1;
      rx_data  <= b;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge pclk);
         ok = rx_ready;
      end
   endtask
   // released data line shows the inverse, not the last byte
   task automatic quiet();
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
         cnt++;
         if (tx_last) begin
            flen.push_back(cnt);
            cnt = 0;
         end
      end
   end
endmodule // sdp_host_model
`default_nettype wire

// file: sdp_ms_tick.sv
/*
 * millisecond tick divider, restartable so the idle time runs from a byte.
 * assumes pclk at the rate the cycle count is derived from.
 */
`default_nettype none
module sdp_ms_tick #(
   parameter int CYCLES = sdp_pkg::MS_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic restart,
   output var  logic tick
);
   logic [31:0] cnt_ff;

   wire wrap = (cnt_ff == 32'(CYCLES - 1));
   assign tick = wrap && !restart;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 32'h0000_0000;
      end else if (restart || wrap) begin
         cnt_ff <= 32'h0000_0000;
      end else begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
      end
   end
endmodule : sdp_ms_tick
`default_nettype wire

// file: sdp_packer.sv
/*
 * serial data packer: collects received bytes in a 1k buffer and releases
 * them as one frame on delimiter, idle timeout, length limit or full buffer.
 * assumes an apb master on pclk, a byte source and a frame sink on pclk.
 */
// Implementation choices: the address map and the APB interface to the registers.
// Notes on behaviour
// - post option none: frame released as soon as the whole delimiter arrives.
// - post option one: frame released after exactly one more byte.
// - post option two: frame released after exactly two more bytes.
// - post option has no effect while the first delimiter is zero.
// - with two-byte match on and both delimiters set, post handling starts after both are received.
// - idle timeout 0 to 65535 ms, reset value 0, zero disables it.
// - nonzero timeout and no byte for that long releases buffered data.
// - timeout disabled means data waits for a delimiter without limit.
// - delimiters are 8-bit, zero unused; both zero disables delimiter packing.
// - a full 1k buffer is released as a frame and cleared.
// - max length 1 to 1024 releases at that fill; zero means no limit.
// - two-byte match needs first then second; one-byte match takes either.
`default_nettype none
module sdp_packer #(
   parameter int MS_CYCLES = sdp_pkg::MS_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output var  logic        rx_ready,
   output var  logic        tx_valid,
   output var  logic [7:0]  tx_data,
   output var  logic        tx_last,
   input  wire logic        tx_ready
);
   localparam int CW = sdp_pkg::CNT_W;
   localparam logic [CW-1:0] BUF_FULL = CW'(sdp_pkg::BUF_DEPTH);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   sdp_strm_if #(.WIDTH(sdp_pkg::BYTE_W)) rx_strm ();

   logic [31:0]          ctrl_ff;
   logic [31:0]          tout_ff;
   logic [31:0]          mlen_ff;
   logic [31:0]          prdata_ff;
   logic                 pready_ff;
   logic                 pslverr_ff;
   logic [7:0]           buf_ff [sdp_pkg::BUF_DEPTH];
   sdp_pkg::sdp_state_e  state_ff;
   logic [CW-1:0]        cnt_ff;
   logic [CW-1:0]        frm_len_ff;
   logic [CW-1:0]        rd_idx_ff;
   logic [7:0]           prev_ff;
   logic                 prev_ok_ff;
   logic                 post_pend_ff;
   logic [1:0]           post_left_ff;
   logic [15:0]          idle_ms_ff;
   logic [15:0]          frames_ff;
   logic                 tx_valid_ff;
   logic [7:0]           tx_data_ff;
   logic                 tx_last_ff;
   logic                 nxt_tx_valid;
   logic                 ms_tick;

   function automatic logic [31:0] apb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return ((new_v & m) | (old_v & ~m)) & mask;
   endfunction

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   wire setup     = psel && !penable;
   wire wr_commit = psel && penable && pready_ff && pwrite;
   wire hit_ctrl  = (paddr == sdp_pkg::OFS_CTRL);
   wire hit_tout  = (paddr == sdp_pkg::OFS_TIMEOUT);
   wire hit_mlen  = (paddr == sdp_pkg::OFS_MAXLEN);
   wire hit_stat  = (paddr == sdp_pkg::OFS_STATUS);
   wire unmapped  = !(hit_ctrl || hit_tout || hit_mlen || hit_stat);

   wire [31:0] stat_word = {frames_ff, 4'h0, (state_ff == sdp_pkg::SDP_ST_SEND),
                            cnt_ff};
   wire [31:0] rd_word   = hit_ctrl ? ctrl_ff :
                           hit_tout ? tout_ff :
                           hit_mlen ? mlen_ff :
                           hit_stat ? stat_word : 32'h0000_0000;

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && unmapped;
         prdata_ff  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= sdp_pkg::CTRL_RST;
         tout_ff <= sdp_pkg::TIMEOUT_RST;
         mlen_ff <= sdp_pkg::MAXLEN_RST;
      end else if (wr_commit) begin
         if (hit_ctrl) ctrl_ff <= apb_merge(ctrl_ff, pwdata, pstrb, sdp_pkg::CTRL_MASK);
         if (hit_tout) tout_ff <= apb_merge(tout_ff, pwdata, pstrb, sdp_pkg::TIMEOUT_MASK);
         if (hit_mlen) mlen_ff <= apb_merge(mlen_ff, pwdata, pstrb, sdp_pkg::MAXLEN_MASK);
      end
   end

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   wire [7:0]  delim1    = ctrl_ff[sdp_pkg::CTRL_D1_LSB +: 8];
   wire [7:0]  delim2    = ctrl_ff[sdp_pkg::CTRL_D2_LSB +: 8];
   wire        match_two = ctrl_ff[sdp_pkg::CTRL_MATCH2];
   wire [1:0]  post_opt  = ctrl_ff[sdp_pkg::CTRL_POST_LSB +: 2];
   wire [15:0] tout_ms   = tout_ff[15:0];
   wire [CW-1:0] max_len = mlen_ff[CW-1:0];
   wire        d1_en     = (delim1 != 8'h00);
   wire        d2_en     = (delim2 != 8'h00);
   wire [1:0]  post_n    = !d1_en ? 2'h0 :
                           (post_opt == sdp_pkg::SDP_POST_ONE) ? 2'h1 :
                           (post_opt == sdp_pkg::SDP_POST_TWO) ? 2'h2 : 2'h0;

   // ---------------------------------------------------------------
   // input fifo
   // ---------------------------------------------------------------
   sdp_fifo #(
      .WIDTH (sdp_pkg::BYTE_W),
      .DEPTH (sdp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_valid (rx_valid),
      .in_data  (rx_data),
      .in_ready (rx_ready),
      .dout     (rx_strm.src)
   );

   // ---------------------------------------------------------------
   // release decisions
   // ---------------------------------------------------------------
   wire          collect  = (state_ff == sdp_pkg::SDP_ST_COLLECT);
   wire          take     = collect && rx_strm.valid;
   wire [7:0]    cur      = rx_strm.data;
   wire [CW-1:0] new_cnt  = cnt_ff + CW'(1);
   wire          pair_hit = prev_ok_ff && (prev_ff == delim1) && (cur == delim2);
   wire          one_hit  = (d1_en && cur == delim1) || (d2_en && cur == delim2);
   wire          delim_hit = (match_two && d1_en && d2_en) ? pair_hit : one_hit;
   wire          dl_rel   = !post_pend_ff && delim_hit && (post_n == 2'h0);
   wire          post_rel = post_pend_ff && (post_left_ff == 2'h1);
   wire          len_hit  = (new_cnt == BUF_FULL) ||
                            ((max_len != '0) && (new_cnt >= max_len));
   wire          byte_rel = take && (dl_rel || post_rel || len_hit);
   wire          tout_rel = collect && !take && (tout_ms != 16'h0000) &&
                            (cnt_ff != '0) && (idle_ms_ff == tout_ms);

   assign rx_strm.ready = collect;

   sdp_ms_tick #(
      .CYCLES (MS_CYCLES)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (take || !collect),
      .tick    (ms_tick)
   );

   // ---------------------------------------------------------------
   // frame buffer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (take) begin
         buf_ff[cnt_ff[CW-2:0]] <= cur;
      end
   end

   // ---------------------------------------------------------------
   // collect and send
   // ---------------------------------------------------------------
   wire out_free = !tx_valid_ff || tx_ready;
   wire load     = !collect && (rd_idx_ff != frm_len_ff) && out_free;
   wire done     = !collect && (rd_idx_ff == frm_len_ff) && out_free;

   assign nxt_tx_valid = load ? 1'b1 : (tx_ready ? 1'b0 : tx_valid_ff);
   assign tx_valid = tx_valid_ff;
   assign tx_data  = tx_data_ff;
   assign tx_last  = tx_last_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= sdp_pkg::SDP_ST_COLLECT;
         cnt_ff       <= '0;
         frm_len_ff   <= '0;
         rd_idx_ff    <= '0;
         prev_ff      <= 8'h00;
         prev_ok_ff   <= 1'b0;
         post_pend_ff <= 1'b0;
         post_left_ff <= 2'h0;
         idle_ms_ff   <= 16'h0000;
         frames_ff    <= 16'h0000;
      end else if (collect) begin
         if (byte_rel || tout_rel) begin
            state_ff     <= sdp_pkg::SDP_ST_SEND;
            frm_len_ff   <= byte_rel ? new_cnt : cnt_ff;
            cnt_ff       <= byte_rel ? new_cnt : cnt_ff;
            rd_idx_ff    <= '0;
            prev_ok_ff   <= 1'b0;
            post_pend_ff <= 1'b0;
            idle_ms_ff   <= 16'h0000;
         end else if (take) begin
            cnt_ff     <= new_cnt;
            prev_ff    <= cur;
            prev_ok_ff <= 1'b1;
            idle_ms_ff <= 16'h0000;
            if (post_pend_ff) begin
               post_left_ff <= post_left_ff - 2'h1;
            end else if (delim_hit) begin
               post_pend_ff <= 1'b1;
               post_left_ff <= post_n;
            end
         end else if (ms_tick && cnt_ff != '0 && idle_ms_ff != 16'hFFFF) begin
            idle_ms_ff <= idle_ms_ff + 16'h0001;
         end
      end else begin
         if (load) begin
            rd_idx_ff <= rd_idx_ff + CW'(1);
         end
         if (done) begin
            state_ff  <= sdp_pkg::SDP_ST_COLLECT;
            cnt_ff    <= '0;
            frames_ff <= frames_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff  <= 8'h00;
         tx_last_ff  <= 1'b0;
      end else begin
         tx_valid_ff <= nxt_tx_valid;
         if (load) begin
            tx_data_ff <= buf_ff[rd_idx_ff[CW-2:0]];
            tx_last_ff <= (rd_idx_ff + CW'(1) == frm_len_ff);
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_delim_release: assert property (
      take && !post_pend_ff && delim_hit && post_n == 2'h0
      |=> state_ff == sdp_pkg::SDP_ST_SEND && frm_len_ff == $past(new_cnt))
      else $error("delimiter did not release the frame");

   chk_post_one: assert property (
      take && !post_pend_ff && delim_hit && post_n == 2'h1 && !len_hit
      |=> collect && post_pend_ff && post_left_ff == 2'h1)
      else $error("post one byte not armed");

   chk_post_two: assert property (
      take && !post_pend_ff && delim_hit && post_n == 2'h2 && !len_hit
      ##1 take && !len_hit |=> collect && post_left_ff == 2'h1)
      else $error("post two bytes released early");

   chk_post_gate: assert property (
      take && !post_pend_ff && delim_hit && !d1_en
      |=> state_ff == sdp_pkg::SDP_ST_SEND)
      else $error("post option used without first delimiter");

   chk_pair_order: assert property (
      take && match_two && d1_en && d2_en && !pair_hit && !post_pend_ff && !len_hit
      |=> collect)
      else $error("two byte match released without sequence");

   chk_tout_off: assert property (
      collect && !take && tout_ms == 16'h0000 |=> collect)
      else $error("release with timeout disabled");

   chk_tout_fire: assert property (
      collect && !take && tout_ms != 16'h0000 && cnt_ff != '0 && idle_ms_ff == tout_ms
      |=> !collect && frm_len_ff == $past(cnt_ff))
      else $error("idle timeout did not release");

   chk_empty_hold: assert property (
      collect && cnt_ff == '0 && !take |=> collect && !tx_valid_ff)
      else $error("frame from empty buffer");

   chk_buf_full: assert property (
      take && cnt_ff == BUF_FULL - CW'(1) |=> !collect && frm_len_ff == BUF_FULL)
      else $error("full buffer not released");

   chk_max_len: assert property (
      take && max_len != '0 && new_cnt == max_len |=> !collect && frm_len_ff == max_len)
      else $error("max length not honoured");

   chk_no_delim: assert property (
      take && !d1_en && !d2_en && !len_hit && !post_pend_ff |=> collect)
      else $error("release with delimiters disabled");

   chk_post_release: assert property (
      take && post_pend_ff && post_left_ff == 2'h1 |=> !collect)
      else $error("post byte count reached without release");

   chk_idle_clear: assert property (
      take |=> idle_ms_ff == 16'h0000)
      else $error("idle time not restarted by a byte");

   chk_tout_wait: assert property (
      collect && !take && tout_ms != 16'h0000 && idle_ms_ff < tout_ms |=> collect)
      else $error("idle release before the timeout");

   chk_empty_idle: assert property (
      collect && cnt_ff == '0 |=> idle_ms_ff == 16'h0000)
      else $error("idle time counted with empty buffer");
endmodule : sdp_packer
`default_nettype wire

// file: sdp_pkg.sv
/*
 * constants, enumerations and register map of the serial data packer.
 * assumes a 25 MHz pclk and a 32-bit apb register bus.
 */
`default_nettype none
package sdp_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_NS        = 40;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYC        = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int MS_CW         = 16;
   // ---------------------------------------------------------------
   // buffers
   // ---------------------------------------------------------------
   localparam int BUF_DEPTH     = 1024;
   localparam int CNT_W         = 11;
   localparam int FIFO_DEPTH    = 8;
   localparam int BYTE_W        = 8;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_TIMEOUT = 12'h004;
   localparam logic [11:0] OFS_MAXLEN  = 12'h008;
   localparam logic [11:0] OFS_STATUS  = 12'h00C;
   localparam int CTRL_D1_LSB   = 0;
   localparam int CTRL_D2_LSB   = 8;
   localparam int CTRL_MATCH2   = 16;
   localparam int CTRL_POST_LSB = 17;
   localparam int STAT_SEND     = 11;
   localparam int STAT_FRM_LSB  = 16;
   localparam logic [31:0] CTRL_MASK    = 32'h0007_FFFF;
   localparam logic [31:0] TIMEOUT_MASK = 32'h0000_FFFF;
   localparam logic [31:0] MAXLEN_MASK  = 32'h0000_07FF;
   localparam logic [31:0] CTRL_RST     = 32'h0001_0000;
   localparam logic [31:0] TIMEOUT_RST  = 32'h0000_0000;
   localparam logic [31:0] MAXLEN_RST   = 32'h0000_0000;

   typedef enum logic [1:0] {
      SDP_POST_NONE = 2'h0,
      SDP_POST_ONE  = 2'h1,
      SDP_POST_TWO  = 2'h2
   } sdp_post_e;

   typedef enum logic {
      SDP_ST_COLLECT = 1'b0,
      SDP_ST_SEND    = 1'b1
   } sdp_state_e;
endpackage : sdp_pkg
`default_nettype wire

// file: sdp_strm_if.sv
/*
 * byte stream carrier with valid and ready between packer modules.
 * assumes both ends share pclk.
 */
`default_nettype none
interface sdp_strm_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sdp_strm_if
`default_nettype wire

// file: tb_top.sv
/*
 * self-checking bench of the serial data packer: registers and release causes.
 * assumes the packer files and the far-side model sdp_host_model.
 */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // harness
   // ----------------------------------------
   typedef logic [7:0] sdp_bq_t[$];
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
   logic [7:0]  rx_data, tx_data;
   int          failures = 0;
   int          cmp_count = 0;
   sdp_packer #(.MS_CYCLES(10)) dut (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .rx_valid,
      .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready);
   sdp_host_model p (.pclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
      .tx_last, .tx_ready);
   initial forever #20 pclk = ~pclk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(q, x);
      chk(e, xe);
   endtask
   task automatic cfg(input logic [7:0] d1, d2, input logic m2, input logic [1:0] pv);
      wr(sdp_pkg::OFS_CTRL, {13'h0000, pv, m2, d2, d1});
   endtask
   task automatic seq(input sdp_bq_t s);
      bit ok;
      foreach (s[i]) begin
         p.send(s[i], 200, ok);
         if (!ok) begin
            failures++;
            conclude();
         end
      end
      p.quiet();
   endtask
   task automatic cf(input sdp_bq_t s);
      for (int i = 0; i < 2000 && p.flen.size() == 0; i++)
         @(posedge pclk);
      if (p.flen.size() == 0) begin
         failures++;
         conclude();
      end
      chk(p.flen.pop_front(), s.size());
      foreach (s[i])
         chk(p.got.pop_front(), s[i]);
   endtask
   task automatic nofr(input int c);
      repeat (c) @(posedge pclk);
      chk(p.flen.size(), 0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(sdp_pkg::OFS_CTRL, 32'h0001_0000, 1'b0);
      rd(sdp_pkg::OFS_TIMEOUT, 32'h0000_0000, 1'b0);
      rd(sdp_pkg::OFS_MAXLEN, 32'h0000_0000, 1'b0);
      wr(sdp_pkg::OFS_TIMEOUT, 32'hFFFF_FFFF);
      rd(sdp_pkg::OFS_TIMEOUT, 32'h0000_FFFF, 1'b0);
      rd(12'h010, 32'h0000_0000, 1'b1);
      wr(sdp_pkg::OFS_TIMEOUT, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_delim();
      cfg(8'h0D, 8'h0A, 1'b1, 2'h0);
      seq('{8'h11, 8'h0D, 8'h22, 8'h0D});
      nofr(40);
      seq('{8'h0A});
      cf('{8'h11, 8'h0D, 8'h22, 8'h0D, 8'h0A});
      cfg(8'h0D, 8'h0A, 1'b0, 2'h0);
      seq('{8'h11, 8'h0A});
      cf('{8'h11, 8'h0A});
      seq('{8'h22, 8'h0D});
      cf('{8'h22, 8'h0D});
      cfg(8'h00, 8'h0A, 1'b1, 2'h2);
      seq('{8'h33, 8'h0A});
      cf('{8'h33, 8'h0A});
      $display("test delim done");
   endtask
   task automatic t_post();
      sdp_bq_t e;
      for (int pv = 1; pv <= 2; pv++) begin
         cfg(8'h0D, 8'h0A, 1'b1, 2'(pv));
         e = '{8'h11, 8'h0D, 8'h0A};
         seq(e);
         for (int k = 0; k < pv; k++) begin
            nofr(40);
            seq('{8'h60});
            e.push_back(8'h60);
         end
         cf(e);
      end
      $display("test post done");
   endtask
   task automatic t_time();
      cfg(8'h0D, 8'h0A, 1'b1, 2'h0);
      wr(sdp_pkg::OFS_TIMEOUT, 32'h0000_0003);
      repeat (3) begin
         seq('{8'h11});
         nofr(20);
      end
      cf('{8'h11, 8'h11, 8'h11});
      nofr(100);
      wr(sdp_pkg::OFS_TIMEOUT, 32'h0000_0000);
      seq('{8'h33});
      nofr(200);
      seq('{8'h0D, 8'h0A});
      cf('{8'h33, 8'h0D, 8'h0A});
      $display("test timeout done");
   endtask
   task automatic t_len();
      sdp_bq_t e;
      bit      ok;
      int      n;
      wr(sdp_pkg::OFS_MAXLEN, 32'h0000_0003);
      seq('{8'h41, 8'h42, 8'h43, 8'h44});
      cf('{8'h41, 8'h42, 8'h43});
      seq('{8'h0D, 8'h0A});
      cf('{8'h44, 8'h0D, 8'h0A});
      wr(sdp_pkg::OFS_MAXLEN, 32'h0000_0002);
      p.stall = 1'b1;
      seq('{8'h51, 8'h52});
      repeat (5) @(posedge pclk);
      n  = 0;
      ok = 1'b1;
      while (ok && n < 20) begin
         p.send(8'(8'h70 + n), 20, ok);
         if (ok)
            n++;
      end
      p.quiet();
      chk(n, 8);
      rd(sdp_pkg::OFS_STATUS, 32'h000A_0802, 1'b0);
      p.stall = 1'b0;
      cf('{8'h51, 8'h52});
      for (int i = 0; i < 4; i++)
         cf('{8'(8'h70 + 2 * i), 8'(8'h71 + 2 * i)});
      wr(sdp_pkg::OFS_MAXLEN, 32'h0000_0000);
      e = {};
      repeat (1024) e.push_back(8'h41);
      seq(e);
      cf(e);
      $display("test length done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk(rx_ready, 1'b1);
      chk(tx_valid, 1'b0);
      t_regs();
      t_delim();
      t_post();
      t_time();
      t_len();
      conclude();
   end
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      conclude();
   end
endmodule // tb_top
`default_nettype wire
